//--- design/sdmr_consts.svh
`ifndef SDMR_CONSTS_SVH
`define SDMR_CONSTS_SVH

// ****************************************
// APB register offsets.
// ****************************************
`define SDMR_ADDR_MR0_VIEW 8'h00
`define SDMR_ADDR_MR1_VIEW 8'h04
`define SDMR_ADDR_CTRL 8'h08
`define SDMR_ADDR_DLL_RST 8'h0C
`define SDMR_ADDR_TRP 8'h10
`define SDMR_ADDR_STATUS 8'h14

// ****************************************
// Mode register field positions.
// ****************************************
`define SDMR_MR0_BT 3
`define SDMR_MR0_CL_LO 2
`define SDMR_MR0_DLL_RST 8
`define SDMR_MR0_PPD 12
`define SDMR_MR1_QOFF 12

// ****************************************
// Reset values.
// ****************************************
`define SDMR_RST_CMD_EN 1'h1
`define SDMR_RST_DLL_RST_CYC 8'h10
`define SDMR_RST_TRP_CYC 5'h05

// ****************************************
// Timing.
// ****************************************
`define SDMR_CLK_PERIOD_NS 100
`define SDMR_SLOW_PD_EXIT_NS 240
`define SDMR_FAST_PD_EXIT_NS 60
`define SDMR_SLOW_PD_EXIT_CYC ((`SDMR_SLOW_PD_EXIT_NS + `SDMR_CLK_PERIOD_NS - 1) / `SDMR_CLK_PERIOD_NS)
`define SDMR_FAST_PD_EXIT_CYC ((`SDMR_FAST_PD_EXIT_NS + `SDMR_CLK_PERIOD_NS - 1) / `SDMR_CLK_PERIOD_NS)
`define SDMR_LOCK_WAIT_CYC 10'h200
`define SDMR_WR_INT_DLY 4'h6
`define SDMR_WR_CHOP_PULL 4'h2
`define SDMR_CL_BASE 5'h04

`endif

//--- design/sdmr_decode.sv
`timescale 1ns/1ps
`include "sdmr_consts.svh"

// Operation
// - A3 picks sequential or interleaved beat order.
// - A1:A0 pick fixed eight, on-the-fly, fixed chop.
// - On-the-fly, A12 per command picks chop.
// - Read order from column bits and type.
// - Chopped read drives only first four beats.
// - Chopped write halves by A2; eight-beat linear.
// - Fixed chop starts internal write two earlier.
// - On-the-fly chop writes start like eight-beat.
// - A2,A4,A5,A6 encode whole-clock CAS latency.
// - Read latency is additive plus CAS latency.
// - DLL reset bit clears itself when done.
// - A11:A9 hold recovery; plus precharge gives total.
// - A12 low freezes DLL; slow power-down exit.
// - A12 high keeps DLL; fast power-down exit.
// - Set command with only BA0 high writes register one.
// - Register one A12 clears beat drive on reads, disconnecting data.
// - Additive latency is zero, CAS-1 or CAS-2.
// - Set command with all banks low writes register zero.
module sdmr_decode
	import sdmr_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory command bus and power-down state.
	input wire sdmr_cmd_t cmd,
	input wire logic pd_active,
	// Burst shaping.
	output logic [23:0] beat_order,
	output logic [7:0] beat_drive,
	output logic read_data_start,
	output logic write_int_start,
	// Decoded mode state.
	output logic [4:0] cas_latency_setting,
	output logic [4:0] additive_latency,
	output logic [5:0] read_latency_total,
	output logic [5:0] autoprecharge_total_delay,
	output logic out_disable,
	output logic dll_reset_busy,
	output logic dll_lock_busy,
	output logic dll_frozen,
	output logic pd_exit_busy
);

	// ****************************************
	// State and decode.
	// ****************************************
	sdmr_state_t st_q;
	sdmr_state_t st_d;
	sdmr_bl_t bl_mode;
	logic [4:0] wr_cyc;
	logic cmd_sel;
	logic is_mrs0;
	logic is_mrs1;
	logic is_rd;
	logic is_wr;
	logic chop;
	logic fixed4;

	function automatic logic [2:0] beat_at(input logic [2:0] start, input logic [2:0] i,
		input logic inter);
		logic [2:0] b;
		b = 3'h0;
		if (inter) begin
			b = start ^ i;
		end else begin
			b = {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
		end
		return b;
	endfunction

	assign bl_mode = sdmr_bl_t'(st_q.mr0[1:0]);
	assign cas_latency_setting = `SDMR_CL_BASE + {st_q.mr0[`SDMR_MR0_CL_LO], st_q.mr0[6:4]};

	always_comb begin
		case (st_q.mr1[4:3])
			2'h1: additive_latency = cas_latency_setting - 5'h01;
			2'h2: additive_latency = cas_latency_setting - 5'h02;
			default: additive_latency = 5'h00;
		endcase
	end

	assign read_latency_total = {1'b0, additive_latency} + {1'b0, cas_latency_setting};

	always_comb begin
		case (st_q.mr0[11:9])
			3'h1: wr_cyc = 5'h05;
			3'h2: wr_cyc = 5'h06;
			3'h3: wr_cyc = 5'h07;
			3'h4: wr_cyc = 5'h08;
			3'h5: wr_cyc = 5'h0A;
			3'h6: wr_cyc = 5'h0C;
			3'h7: wr_cyc = 5'h0E;
			default: wr_cyc = 5'h10;
		endcase
	end

	assign autoprecharge_total_delay = {1'b0, wr_cyc} + {1'b0, st_q.trp_cyc};

	assign cmd_sel = st_q.cmd_en && !cmd.cs_n;
	assign is_mrs0 = cmd_sel && !cmd.ras_n && !cmd.cas_n && !cmd.we_n && cmd.ba == 3'h0;
	assign is_mrs1 = cmd_sel && !cmd.ras_n && !cmd.cas_n && !cmd.we_n && cmd.ba == 3'h1;
	assign is_rd = cmd_sel && cmd.ras_n && !cmd.cas_n && cmd.we_n;
	assign is_wr = cmd_sel && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	assign fixed4 = bl_mode == SDMR_BL_FIX4;
	assign chop = fixed4 || (bl_mode == SDMR_BL_OTF && !cmd.addr[12]);

	// ****************************************
	// Next state.
	// ****************************************
	always_comb begin
		st_d = st_q;
		st_d.rd_go = 1'b0;
		st_d.wr_go = 1'b0;
		st_d.pd_prev = pd_active;
		if (st_q.lock_cnt != 10'h000) begin
			st_d.lock_cnt = st_q.lock_cnt - 10'h001;
		end
		if (is_mrs0) begin
			st_d.mr0 = cmd.addr[12:0];
			if (cmd.addr[`SDMR_MR0_DLL_RST]) begin
				st_d.dll_cnt = st_q.dll_rst_cyc;
				st_d.lock_cnt = 10'h000;
			end
		end else if (st_q.mr0[`SDMR_MR0_DLL_RST]) begin
			if (st_q.dll_cnt == 8'h00) begin
				st_d.mr0[`SDMR_MR0_DLL_RST] = 1'b0;
				st_d.lock_cnt = `SDMR_LOCK_WAIT_CYC;
			end else begin
				st_d.dll_cnt = st_q.dll_cnt - 8'h01;
			end
		end
		if (is_mrs1) begin
			st_d.mr1 = cmd.addr[12:0];
		end
		if (is_rd) begin
			for (int i = 0; i < 8; i++) begin
				st_d.order[3*i +: 3] = beat_at(cmd.addr[2:0], 3'(i), st_q.mr0[`SDMR_MR0_BT]);
			end
			st_d.drive = (chop ? 8'h0F : 8'hFF) & {8{!st_q.mr1[`SDMR_MR1_QOFF]}};
			st_d.rd_cnt = read_latency_total - 6'h01;
			st_d.rd_pend = 1'b1;
		end else if (st_q.rd_pend) begin
			if (st_q.rd_cnt == 6'h00) begin
				st_d.rd_go = 1'b1;
				st_d.rd_pend = 1'b0;
			end else begin
				st_d.rd_cnt = st_q.rd_cnt - 6'h01;
			end
		end
		if (is_wr) begin
			for (int i = 0; i < 8; i++) begin
				if (chop) begin
					st_d.order[3*i +: 3] = {cmd.addr[2], 2'(i)};
				end else begin
					st_d.order[3*i +: 3] = 3'(i);
				end
			end
			st_d.drive = chop ? 8'h0F : 8'hFF;
			if (fixed4) begin
				st_d.wr_cnt = `SDMR_WR_INT_DLY - `SDMR_WR_CHOP_PULL - 4'h1;
			end else begin
				st_d.wr_cnt = `SDMR_WR_INT_DLY - 4'h1;
			end
			st_d.wr_pend = 1'b1;
		end else if (st_q.wr_pend) begin
			if (st_q.wr_cnt == 4'h0) begin
				st_d.wr_go = 1'b1;
				st_d.wr_pend = 1'b0;
			end else begin
				st_d.wr_cnt = st_q.wr_cnt - 4'h1;
			end
		end
		if (st_q.pd_prev && !pd_active) begin
			if (st_q.mr0[`SDMR_MR0_PPD]) begin
				st_d.exit_cnt = 4'(`SDMR_FAST_PD_EXIT_CYC);
			end else begin
				st_d.exit_cnt = 4'(`SDMR_SLOW_PD_EXIT_CYC);
			end
		end else if (st_q.exit_cnt != 4'h0) begin
			st_d.exit_cnt = st_q.exit_cnt - 4'h1;
		end
		if (psel && penable && pwrite) begin
			case (paddr)
				`SDMR_ADDR_CTRL: st_d.cmd_en = pwdata[0];
				`SDMR_ADDR_DLL_RST: st_d.dll_rst_cyc = pwdata[7:0];
				`SDMR_ADDR_TRP: st_d.trp_cyc = pwdata[4:0];
				default: st_d.cmd_en = st_q.cmd_en;
			endcase
		end
		if (psel && !penable) begin
			st_d.pslverr = 1'b0;
			case (paddr)
				`SDMR_ADDR_MR0_VIEW: st_d.prdata = {19'h0_0000, st_q.mr0};
				`SDMR_ADDR_MR1_VIEW: st_d.prdata = {19'h0_0000, st_q.mr1};
				`SDMR_ADDR_CTRL: st_d.prdata = {31'h0000_0000, st_q.cmd_en};
				`SDMR_ADDR_DLL_RST: st_d.prdata = {24'h00_0000, st_q.dll_rst_cyc};
				`SDMR_ADDR_TRP: st_d.prdata = {27'h000_0000, st_q.trp_cyc};
				`SDMR_ADDR_STATUS: st_d.prdata = {2'h0, pd_exit_busy, dll_lock_busy, dll_reset_busy,
					autoprecharge_total_delay, wr_cyc, read_latency_total, additive_latency,
					cas_latency_setting};
				default: begin
					st_d.prdata = 32'h0000_0000;
					st_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.cmd_en <= `SDMR_RST_CMD_EN;
			st_q.dll_rst_cyc <= `SDMR_RST_DLL_RST_CYC;
			st_q.trp_cyc <= `SDMR_RST_TRP_CYC;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	assign prdata = st_q.prdata;
	assign pready = 1'b1;
	assign pslverr = st_q.pslverr;
	assign beat_order = st_q.order;
	assign beat_drive = st_q.drive;
	assign read_data_start = st_q.rd_go;
	assign write_int_start = st_q.wr_go;
	assign out_disable = st_q.mr1[`SDMR_MR1_QOFF];
	assign dll_reset_busy = st_q.mr0[`SDMR_MR0_DLL_RST];
	assign dll_lock_busy = st_q.lock_cnt != 10'h000;
	assign dll_frozen = pd_active && !st_q.mr0[`SDMR_MR0_PPD];
	assign pd_exit_busy = st_q.exit_cnt != 4'h0;

	// ****************************************
	// Checks.
	// ****************************************
	logic [5:0] rd_age_h;
	logic [5:0] rl_cap_h;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_age_h <= 6'h00;
			rl_cap_h <= 6'h00;
		end else if (is_rd) begin
			rd_age_h <= 6'h00;
			rl_cap_h <= read_latency_total;
		end else if (rd_age_h != 6'h3F) begin
			rd_age_h <= rd_age_h + 6'h01;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wr_quiet;
		!is_wr && !write_int_start;
	endsequence

	property p_seq_order;
		is_rd && !st_q.mr0[3] |=> beat_order[5:3] == {$past(cmd.addr[2]), $past(cmd.addr[1:0]) + 2'h1};
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("Sequential second beat wrong.");

	property p_int_order;
		is_rd && st_q.mr0[3] |=> beat_order[23:21] == ($past(cmd.addr[2:0]) ^ 3'h7);
	endproperty
	a_int_order: assert property (p_int_order) else $error("Interleaved last beat wrong.");

	property p_chop_read;
		is_rd && chop && !st_q.mr1[12] |=> beat_drive == 8'h0F;
	endproperty
	a_chop_read: assert property (p_chop_read) else $error("Chopped read drives late beats.");

	property p_wr_linear;
		is_wr && !chop |=> beat_order == 24'hFA_C688 && beat_drive == 8'hFF;
	endproperty
	a_wr_linear: assert property (p_wr_linear) else $error("Eight-beat write order wrong.");

	property p_wr_fix4;
		(is_wr && fixed4) ##1 s_wr_quiet [*4] |=> write_int_start;
	endproperty
	a_wr_fix4: assert property (p_wr_fix4) else $error("Fixed chop write start not early.");

	property p_wr_otf;
		(is_wr && bl_mode == SDMR_BL_OTF) ##1 s_wr_quiet [*6] |=> write_int_start;
	endproperty
	a_wr_otf: assert property (p_wr_otf) else $error("On-the-fly write start wrong.");

	property p_rl;
		read_data_start |-> rd_age_h == rl_cap_h;
	endproperty
	a_rl: assert property (p_rl) else $error("Read start not at total latency.");

	property p_dll_clear;
		dll_reset_busy && st_q.dll_cnt == 8'h00 && !is_mrs0 |=> !dll_reset_busy && dll_lock_busy;
	endproperty
	a_dll_clear: assert property (p_dll_clear) else $error("DLL reset bit did not clear.");

	property p_mrs1;
		is_mrs1 |=> st_q.mr1 == $past(cmd.addr[12:0]);
	endproperty
	a_mrs1: assert property (p_mrs1) else $error("Register one not loaded.");

	property p_slow_exit;
		$fell(pd_active) && !st_q.mr0[12] |=> pd_exit_busy ##1 pd_exit_busy ##1 pd_exit_busy
			##1 !pd_exit_busy;
	endproperty
	a_slow_exit: assert property (p_slow_exit) else $error("Slow exit wait wrong.");

	property p_fast_exit;
		$fell(pd_active) && st_q.mr0[12] |=> pd_exit_busy ##1 !pd_exit_busy;
	endproperty
	a_fast_exit: assert property (p_fast_exit) else $error("Fast exit wait wrong.");

endmodule

//--- design/sdmr_pkg.sv
package sdmr_pkg;

	// ****************************************
	// Burst length modes and bus carriers.
	// ****************************************
	typedef enum logic [1:0] {
		SDMR_BL_FIX8,
		SDMR_BL_OTF,
		SDMR_BL_FIX4,
		SDMR_BL_RSV
	} sdmr_bl_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [13:0] addr;
	} sdmr_cmd_t;

	typedef struct packed {
		logic [12:0] mr0;
		logic [12:0] mr1;
		logic cmd_en;
		logic [7:0] dll_rst_cyc;
		logic [4:0] trp_cyc;
		logic [7:0] dll_cnt;
		logic [9:0] lock_cnt;
		logic [5:0] rd_cnt;
		logic rd_pend;
		logic rd_go;
		logic [3:0] wr_cnt;
		logic wr_pend;
		logic wr_go;
		logic [23:0] order;
		logic [7:0] drive;
		logic pd_prev;
		logic [3:0] exit_cnt;
		logic [31:0] prdata;
		logic pslverr;
	} sdmr_state_t;

endpackage

//--- test/sdmr_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************
// Controller model on the command bus.
// ****************************************
module sdmr_ctrl_model
	import sdmr_pkg::*;
(
	// Clock.
	input wire logic pclk,
	// Command bus.
	output sdmr_cmd_t cmd
);
	initial cmd = {1'b1, 3'h7, 3'h0, 14'h0000};
	// One selected cycle, then deselect with every line inverted.
	task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a);
		@(posedge pclk);
		cmd <= {1'b0, rcw, ba, a};
		@(posedge pclk);
		cmd <= {1'b1, ~rcw, ~ba, ~a};
	endtask
	// Mode set with reserved bits, the test bit and nominal termination held at zero.
	task automatic mode_set(input logic one, input logic [12:0] v);
		logic [12:0] keep;
		keep = one ? 13'h10BB : 13'h1F7F;
		issue(3'h0, {2'b00, one}, {1'b0, v & keep});
	endtask
	// Read with the chop choice on address bit twelve.
	task automatic rd(input logic eight, input logic [2:0] col);
		issue(3'h5, 3'h0, {1'b0, eight, 9'h000, col});
	endtask
	// Write with the chop choice on address bit twelve.
	task automatic wr(input logic eight, input logic [2:0] col);
		issue(3'h4, 3'h0, {1'b0, eight, 9'h000, col});
	endtask
endmodule

//--- test/sdmr_mode_reg_burst_decode_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Self-checking bench for the mode register decode.
// ****************************************
module sdmr_mode_reg_burst_decode_tb_top
	import sdmr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pd_active = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, read_data_start, write_int_start, out_disable;
	logic dll_reset_busy, dll_lock_busy, dll_frozen, pd_exit_busy;
	sdmr_cmd_t cmd;
	logic [23:0] beat_order, e;
	logic [7:0] beat_drive;
	logic [4:0] cas_latency_setting, additive_latency;
	logic [5:0] read_latency_total, autoprecharge_total_delay;
	int miscompares = 0;
	int checks_done = 0;

	always #50 pclk = ~pclk;

	sdmr_ctrl_model u_ctrl (.pclk, .cmd);
	sdmr_decode DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cmd, .pd_active, .beat_order, .beat_drive, .read_data_start,
		.write_int_start, .cas_latency_setting, .additive_latency, .read_latency_total,
		.autoprecharge_total_delay, .out_disable, .dll_reset_busy, .dll_lock_busy,
		.dll_frozen, .pd_exit_busy);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic lat(input logic wrs, input int exp, input string what);
		int n;
		for (n = 0; n < 64; n++) begin
			#1;
			if ((wrs ? write_int_start : read_data_start) === 1'b1) break;
			@(posedge pclk);
		end
		chk(what, n, exp);
	endtask

	function automatic logic [23:0] exp_order(input logic il, input logic [2:0] s);
		logic [23:0] o;
		for (int i = 0; i < 8; i++) begin
			o[3*i +: 3] = il ? s ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
		end
		return o;
	endfunction

	task automatic t_reset();
		chk("cas", cas_latency_setting, 5'h04);
		chk("rl", read_latency_total, 6'h04);
		chk("apd", autoprecharge_total_delay, 6'h15);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("status", rd, 32'h02B0_1004);
		chk("status err", err, 1'b0);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped err", err, 1'b1);
		chk("unmapped data", rd, 32'h0000_0000);
	endtask

	task automatic t_order();
		for (int i = 0; i < 2; i++) begin
			u_ctrl.mode_set(1'b0, {9'h000, i[0], 3'h0});
			for (int s = 0; s < 8; s++) begin
				u_ctrl.rd(1'b1, s[2:0]);
				#1;
				chk("order", beat_order, exp_order(i[0], s[2:0]));
				if (s == 1) begin
					chk("order lit", beat_order, (i == 0) ? 24'h9F_50D1 : 24'hDE_54C1);
				end
				chk("drive", beat_drive, 8'hFF);
			end
		end
	endtask

	task automatic t_chop();
		u_ctrl.mode_set(1'b0, 13'h0002);
		u_ctrl.rd(1'b1, 3'h5);
		#1;
		e = exp_order(1'b0, 3'h5);
		chk("chop order", beat_order[11:0], e[11:0]);
		chk("chop drive", beat_drive, 8'h0F);
		u_ctrl.wr(1'b1, 3'h6);
		lat(1'b1, 4, "chop wr start");
		chk("chop wr order", beat_order[11:0], 12'hFAC);
		chk("chop wr drive", beat_drive, 8'h0F);
		u_ctrl.mode_set(1'b0, 13'h0001);
		u_ctrl.wr(1'b0, 3'h3);
		lat(1'b1, 6, "otf wr start");
		chk("otf wr order", beat_order[11:0], 12'h688);
		u_ctrl.wr(1'b1, 3'h5);
		lat(1'b1, 6, "bl8 wr start");
		chk("bl8 wr order", beat_order, exp_order(1'b0, 3'h0));
		chk("bl8 wr drive", beat_drive, 8'hFF);
	endtask

	task automatic t_lat();
		u_ctrl.mode_set(1'b0, 13'h0030);
		u_ctrl.mode_set(1'b1, 13'h0008);
		u_ctrl.rd(1'b1, 3'h0);
		lat(1'b0, 13, "rl al1");
		chk("cas", cas_latency_setting, 5'h07);
		chk("al1", additive_latency, 5'h06);
		u_ctrl.mode_set(1'b0, 13'h0004);
		u_ctrl.mode_set(1'b1, 13'h0010);
		u_ctrl.rd(1'b1, 3'h0);
		lat(1'b0, 22, "rl al2");
		chk("cas2", cas_latency_setting, 5'h0C);
		chk("rl2", read_latency_total, 6'h16);
		u_ctrl.mode_set(1'b1, 13'h1000);
		u_ctrl.mode_set(1'b0, 13'h0002);
		u_ctrl.rd(1'b1, 3'h0);
		#1;
		chk("qoff", out_disable, 1'b1);
		chk("qoff drive", beat_drive, 8'h00);
		u_ctrl.mode_set(1'b1, 13'h0000);
		#1;
		chk("al0", additive_latency, 5'h00);
	endtask

	task automatic t_misc();
		int n;
		apb(1'b1, 8'h10, 32'h0000_0007);
		u_ctrl.mode_set(1'b0, 13'h0200);
		#1;
		chk("apd5", autoprecharge_total_delay, 6'h0C);
		apb(1'b1, 8'h0C, 32'h0000_0003);
		u_ctrl.mode_set(1'b0, 13'h0100);
		#1;
		chk("dll busy", dll_reset_busy, 1'b1);
		repeat (4) @(posedge pclk);
		#1;
		chk("dll clear", dll_reset_busy, 1'b0);
		chk("lock", dll_lock_busy, 1'b1);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk("mr0 view", rd, 32'h0000_0000);
		repeat (510) @(posedge pclk);
		#1;
		chk("lock done", dll_lock_busy, 1'b0);
		for (int k = 0; k < 2; k++) begin
			u_ctrl.mode_set(1'b0, {k[0], 12'h000});
			pd_active <= 1'b1;
			@(posedge pclk);
			#1;
			chk("frozen", dll_frozen, !k[0]);
			@(posedge pclk);
			pd_active <= 1'b0;
			n = 0;
			repeat (8) begin
				@(posedge pclk);
				#1;
				if (pd_exit_busy === 1'b1) n++;
			end
			chk("exit", n, k[0] ? 1 : 3);
		end
		apb(1'b1, 8'h08, 32'h0000_0000);
		u_ctrl.mode_set(1'b0, 13'h0008);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk("cmd off", rd, 32'h0000_1000);
		apb(1'b1, 8'h08, 32'h0000_0001);
		u_ctrl.mode_set(1'b0, 13'h0003);
		u_ctrl.rd(1'b0, 3'h0);
		#1;
		chk("mode 11 drive", beat_drive, 8'hFF);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		t_reset();
		t_order();
		t_chop();
		t_lat();
		t_misc();
		print_verdict();
	end

	initial begin
		#(20000 * 100);
		miscompares++;
		print_verdict();
	end
endmodule
